/* File: hw/ctc_consts.vh */
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH

// test-mode setting codes
`define CTC_MODE_W         2
`define CTC_MODE_DISABLED  2'h0
`define CTC_MODE_TEST      2'h1
`define CTC_MODE_BLOCKED   2'h2

// contact test command codes
`define CTC_CMD_W          2
`define CTC_CMD_NOP        2'h0
`define CTC_CMD_APPLY      2'h1
`define CTC_CMD_REMOVE     2'h2

// probe selector
`define CTC_SEL_W          9
`define CTC_SEL_DEF_BASE   9'h040
`define CTC_PROBES         8

// indicator test timing
`define CTC_CLK_HZ         40000000
`define CTC_TICK_HZ        1000
`define CTC_IND_TEST_MS    2000
`define CTC_PRESCALE       (`CTC_CLK_HZ / `CTC_TICK_HZ)

// cause of transmission codes
`define CTC_COT_W          8
`define CTC_COT_NORMAL     8'h01
`define CTC_COT_TEST       8'h07

`endif

/* File: hw/ctc_tick_divider.v */
`timescale 1ns/1ps
`include "ctc_consts.vh"

module ctc_tick_divider
#(
    parameter DIVIDE = `CTC_PRESCALE,
    parameter CNT_W  = 16
)
(
    input  wire clock,
    input  wire rst_b,
    input  wire run,
    output reg  tick_reg
);
    reg [CNT_W-1:0] count_reg;

    // divider only counts while a timed test runs so each run starts aligned
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick_reg  <= 1'b0;
        end
        else if (!run)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick_reg  <= 1'b0;
        end
        else if (count_reg == DIVIDE[CNT_W-1:0] - 1'b1)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick_reg  <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
            tick_reg  <= 1'b0;
        end
    end
endmodule // ctc_tick_divider

/* File: hw/ctc_commission_test.v */
`timescale 1ns/1ps
`include "ctc_consts.vh"

// Overview of operation
// RULE_01 - input view: one bit each, 1 energised
// RULE_02 - output view: commanded contact signals, 1 operated
// RULE_03 - output view shows logic, not inhibited contacts
// RULE_04 - probe view follows eight selected bus signals
// RULE_05 - selectors 0..511, defaults 64 to 71
// RULE_06 - selected signals also drive monitor port
// RULE_07 - eight-bit indicator view, 1 lit
// RULE_08 - mode: disabled, test, inhibited; default disabled
// RULE_09 - test mode: out of service, alarm, indicator
// RULE_10 - mapped energised input also forces test mode
// RULE_11 - inhibited mode also blocks contact drive
// RULE_12 - disabled restores service, releases inhibit
// RULE_13 - pattern bit per contact, default zero
// RULE_14 - pattern writable only in inhibited mode
// RULE_15 - apply drives patterned contacts; command reads nop
// RULE_16 - contacts held until remove; command reads nop
// RULE_17 - indicator test lights all eight for 2s
// RULE_18 - test mode switches cause of transmission
// RULE_19 - test duration from prescaled system clock
// RULE_20 - contact commands ignored unless contacts inhibited
module ctc_commission_test
#(
    parameter N_INPUTS    = 16,
    parameter N_CONTACTS  = 14,
    parameter N_LEDS      = 8,
    parameter BUS_W       = 512,
    parameter PRESCALE    = `CTC_PRESCALE,
    parameter TEST_TICKS  = `CTC_IND_TEST_MS
)
(
    input  wire                     clock,
    input  wire                     rst_b,
    input  wire [N_INPUTS-1:0]      opto_in,
    input  wire [N_INPUTS-1:0]      opto_test_map,
    input  wire [BUS_W-1:0]         internal_signal_bus,
    input  wire [N_CONTACTS-1:0]    contact_cmd,
    input  wire [N_LEDS-1:0]        led_logic,
    input  wire                     sel_wr,
    input  wire [2:0]               sel_idx,
    input  wire [`CTC_SEL_W-1:0]    sel_data,
    input  wire                     mode_wr,
    input  wire [`CTC_MODE_W-1:0]   mode_data,
    input  wire                     pattern_wr,
    input  wire [N_CONTACTS-1:0]    pattern_data,
    input  wire                     contact_test_wr,
    input  wire [`CTC_CMD_W-1:0]    contact_test_data,
    input  wire                     indicator_test_command,
    output reg  [N_INPUTS-1:0]      opto_view_reg,
    output reg  [N_CONTACTS-1:0]    contact_view_reg,
    output reg  [7:0]               probe_view_reg,
    output reg  [7:0]               monitor_port_reg,
    output reg  [N_LEDS-1:0]        indicator_state_view,
    output reg  [N_LEDS-1:0]        led_drive_reg,
    output reg  [N_CONTACTS-1:0]    contact_drive_reg,
    output reg  [`CTC_MODE_W-1:0]   mode_view_reg,
    output reg  [N_CONTACTS-1:0]    pattern_view_reg,
    output reg                      pattern_visible_reg,
    output reg  [`CTC_CMD_W-1:0]    contact_test_view_reg,
    output reg                      indicator_test_busy_reg,
    output reg                      out_of_service_reg,
    output reg                      oos_led_reg,
    output reg                      alarm_reg,
    output reg  [`CTC_COT_W-1:0]    cot_reg
);
    localparam ST_IDLE  = 2'b01;
    localparam ST_LAMP  = 2'b10;
    localparam TICK_W   = 12;

    // selector index to its default stored word; used only for the reset value
    function [`CTC_SEL_W-1:0] sel_default;
        input integer i;
        begin
            sel_default = `CTC_SEL_DEF_BASE + i[`CTC_SEL_W-1:0];
        end
    endfunction

    // opto input pins pass two flops before use
    reg [N_INPUTS-1:0]   opto_s1_reg;
    reg [N_INPUTS-1:0]   opto_s2_reg;
    reg [`CTC_SEL_W-1:0] sel_reg [0:`CTC_PROBES-1];
    reg [`CTC_MODE_W-1:0] mode_reg;
    reg [N_CONTACTS-1:0] pattern_reg;
    reg                  applied_reg;
    reg [1:0]            state_reg;
    reg [TICK_W-1:0]     tick_count_reg;
    wire                 tick;
    wire                 forced_test;
    wire                 in_test;
    wire                 blocked;
    reg [7:0]            probe_next;
    integer              k;
    integer              j;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opto_s1_reg <= {N_INPUTS{1'b0}};
            opto_s2_reg <= {N_INPUTS{1'b0}};
        end
        else
        begin
            opto_s1_reg <= opto_in;
            opto_s2_reg <= opto_s1_reg;
        end
    end

    assign forced_test = |(opto_s2_reg & opto_test_map); // RULE_10
    assign blocked     = (mode_reg == `CTC_MODE_BLOCKED); // RULE_11
    assign in_test     = (mode_reg != `CTC_MODE_DISABLED) || forced_test;

    // selectors: any 9-bit value is legal, so no range clamp is needed
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (j = 0; j < `CTC_PROBES; j = j + 1)
                sel_reg[j] <= sel_default(j); // RULE_05
        end
        else if (sel_wr)
        begin
            sel_reg[sel_idx] <= sel_data; // RULE_05
        end
    end

    always @*
    begin
        probe_next = 8'h00;
        for (k = 0; k < `CTC_PROBES; k = k + 1)
            probe_next[k] = internal_signal_bus[sel_reg[k]]; // RULE_04
    end

    // unknown mode codes are dropped so the mode stays one of three
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            mode_reg <= `CTC_MODE_DISABLED; // RULE_08
        else if (mode_wr && (mode_data == `CTC_MODE_DISABLED ||
                             mode_data == `CTC_MODE_TEST ||
                             mode_data == `CTC_MODE_BLOCKED))
            mode_reg <= mode_data; // RULE_08
    end

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pattern_reg <= {N_CONTACTS{1'b0}}; // RULE_13
        else if (pattern_wr && blocked)
            pattern_reg <= pattern_data; // RULE_14
    end

    // leaving the inhibited mode drops any applied test
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            applied_reg <= 1'b0;
        else if (!blocked)
            applied_reg <= 1'b0; // RULE_12 RULE_20
        else if (contact_test_wr)
        begin
            if (contact_test_data == `CTC_CMD_APPLY)
                applied_reg <= 1'b1; // RULE_15
            else if (contact_test_data == `CTC_CMD_REMOVE)
                applied_reg <= 1'b0; // RULE_16
        end
    end

    ctc_tick_divider
    #(
        .DIVIDE (PRESCALE),
        .CNT_W  (16)
    )
    u_div
    (
        .clock    (clock),
        .rst_b    (rst_b),
        .run      (state_reg == ST_LAMP),
        .tick_reg (tick)
    ); // RULE_19

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg      <= ST_IDLE;
            tick_count_reg <= {TICK_W{1'b0}};
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    tick_count_reg <= {TICK_W{1'b0}};
                    if (indicator_test_command)
                        state_reg <= ST_LAMP; // RULE_17
                end
                ST_LAMP:
                begin
                    if (tick)
                    begin
                        if (tick_count_reg == TEST_TICKS[TICK_W-1:0] - 1'b1)
                            state_reg <= ST_IDLE; // RULE_17
                        tick_count_reg <= tick_count_reg + 1'b1;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opto_view_reg           <= {N_INPUTS{1'b0}};
            contact_view_reg        <= {N_CONTACTS{1'b0}};
            probe_view_reg          <= 8'h00;
            monitor_port_reg        <= 8'h00;
            indicator_state_view    <= {N_LEDS{1'b0}};
            led_drive_reg           <= {N_LEDS{1'b0}};
            contact_drive_reg       <= {N_CONTACTS{1'b0}};
            mode_view_reg           <= `CTC_MODE_DISABLED;
            pattern_view_reg        <= {N_CONTACTS{1'b0}};
            pattern_visible_reg     <= 1'b0;
            contact_test_view_reg   <= `CTC_CMD_NOP;
            indicator_test_busy_reg <= 1'b0;
            out_of_service_reg      <= 1'b0;
            oos_led_reg             <= 1'b0;
            alarm_reg               <= 1'b0;
            cot_reg                 <= `CTC_COT_NORMAL;
        end
        else
        begin
            opto_view_reg    <= opto_s2_reg; // RULE_01
            contact_view_reg <= contact_cmd; // RULE_02 RULE_03
            probe_view_reg   <= probe_next; // RULE_04
            monitor_port_reg <= probe_next; // RULE_06
            if (state_reg == ST_LAMP)
            begin
                indicator_state_view <= {N_LEDS{1'b1}}; // RULE_07 RULE_17
                led_drive_reg        <= {N_LEDS{1'b1}}; // RULE_17
            end
            else
            begin
                indicator_state_view <= led_logic; // RULE_07
                led_drive_reg        <= led_logic;
            end
            // inhibit stops logic drive; only the test pattern reaches pins
            if (blocked && applied_reg)
                contact_drive_reg <= pattern_reg; // RULE_11 RULE_15 RULE_16
            else if (blocked)
                contact_drive_reg <= {N_CONTACTS{1'b0}}; // RULE_11
            else
                contact_drive_reg <= contact_cmd; // RULE_12
            mode_view_reg         <= mode_reg;
            pattern_view_reg      <= blocked ? pattern_reg
                                             : {N_CONTACTS{1'b0}}; // RULE_14
            pattern_visible_reg   <= blocked; // RULE_14
            // commands are one-shot, so the field always reads back nop
            contact_test_view_reg <= `CTC_CMD_NOP; // RULE_15 RULE_16 RULE_20
            indicator_test_busy_reg <= (state_reg == ST_LAMP);
            out_of_service_reg    <= in_test; // RULE_09 RULE_12
            oos_led_reg           <= in_test; // RULE_09
            alarm_reg             <= in_test; // RULE_09
            cot_reg               <= in_test ? `CTC_COT_TEST
                                             : `CTC_COT_NORMAL; // RULE_18
        end
    end
endmodule // ctc_commission_test

/* File: verif/ctc_commission_test_sva.sv */
`timescale 1ns/1ps
`include "ctc_consts.vh"
module ctc_commission_test_sva
#(
    parameter N_INPUTS   = 16,
    parameter N_CONTACTS = 14,
    parameter N_LEDS     = 8,
    parameter PRESCALE   = 4,
    parameter TEST_TICKS = 3
)
(
    input logic                   clock,
    input logic                   rst_b,
    input logic [N_INPUTS-1:0]    opto_in,
    input logic [N_CONTACTS-1:0]  contact_cmd,
    input logic [N_INPUTS-1:0]    opto_view_reg,
    input logic [N_CONTACTS-1:0]  contact_view_reg,
    input logic [7:0]             probe_view_reg,
    input logic [7:0]             monitor_port_reg,
    input logic [N_LEDS-1:0]      indicator_state_view,
    input logic [N_LEDS-1:0]      led_drive_reg,
    input logic [N_CONTACTS-1:0]  contact_drive_reg,
    input logic [1:0]             mode_view_reg,
    input logic [N_CONTACTS-1:0]  pattern_view_reg,
    input logic [1:0]             contact_test_view_reg,
    input logic                   indicator_test_busy_reg,
    input logic                   out_of_service_reg,
    input logic                   oos_led_reg,
    input logic                   alarm_reg,
    input logic [7:0]             cot_reg
);
    localparam int LO = PRESCALE * TEST_TICKS - 1;
    localparam int HI = PRESCALE * TEST_TICKS + 3;
    logic        up_reg;
    logic [31:0] cnt_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // up_reg keeps $past from looking back into reset
    always @(posedge clock or negedge rst_b)
        if (!rst_b)
        begin
            up_reg  <= 1'b0;
            cnt_reg <= 32'h0;
        end
        else
        begin
            up_reg  <= 1'b1;
            cnt_reg <= indicator_test_busy_reg ? cnt_reg + 32'h1 : 32'h0;
        end
    sequence s_lamps_on; indicator_test_busy_reg [*2]; endsequence
    sequence s_opto_steady; $stable(opto_in) [*4]; endsequence
    property p_cview; up_reg |-> contact_view_reg == $past(contact_cmd);
    endproperty
    a_cview: assert property (p_cview)
        else $error("contact view not following commands");
    property p_probe; probe_view_reg == monitor_port_reg; endproperty
    a_probe: assert property (p_probe)
        else $error("monitor port differs from probe view");
    property p_opto; s_opto_steady |-> opto_view_reg == opto_in; endproperty
    a_opto: assert property (p_opto)
        else $error("input view wrong");
    property p_cot; cot_reg == (out_of_service_reg ? `CTC_COT_TEST
        : `CTC_COT_NORMAL); endproperty
    a_cot: assert property (p_cot)
        else $error("transmission cause wrong");
    property p_oos; oos_led_reg == out_of_service_reg
        && alarm_reg == out_of_service_reg; endproperty
    a_oos: assert property (p_oos)
        else $error("service lamp or alarm wrong");
    property p_hide; mode_view_reg != `CTC_MODE_BLOCKED
        |-> pattern_view_reg == '0; endproperty
    a_hide: assert property (p_hide)
        else $error("pattern shown outside inhibit");
    property p_nop; contact_test_view_reg == `CTC_CMD_NOP; endproperty
    a_nop: assert property (p_nop)
        else $error("command field not idle");
    property p_lamps; s_lamps_on |-> &indicator_state_view && &led_drive_reg;
    endproperty
    a_lamps: assert property (p_lamps)
        else $error("lamps not all lit in test");
    property p_len; $fell(indicator_test_busy_reg) |-> cnt_reg >= LO
        && cnt_reg <= HI; endproperty
    a_len: assert property (p_len)
        else $error("lamp test length wrong");
    property p_free; up_reg && mode_view_reg == `CTC_MODE_DISABLED
        && $past(mode_view_reg) == `CTC_MODE_DISABLED
        |-> contact_drive_reg == contact_view_reg; endproperty
    a_free: assert property (p_free)
        else $error("contacts not following logic");
endmodule // ctc_commission_test_sva
bind ctc_commission_test ctc_commission_test_sva #(.N_INPUTS(N_INPUTS),
    .N_CONTACTS(N_CONTACTS), .N_LEDS(N_LEDS), .PRESCALE(PRESCALE),
    .TEST_TICKS(TEST_TICKS)) u_sva (.clock(clock), .rst_b(rst_b),
    .opto_in(opto_in), .contact_cmd(contact_cmd),
    .opto_view_reg(opto_view_reg), .contact_view_reg(contact_view_reg),
    .probe_view_reg(probe_view_reg), .monitor_port_reg(monitor_port_reg),
    .indicator_state_view(indicator_state_view),
    .led_drive_reg(led_drive_reg), .contact_drive_reg(contact_drive_reg),
    .mode_view_reg(mode_view_reg), .pattern_view_reg(pattern_view_reg),
    .contact_test_view_reg(contact_test_view_reg),
    .indicator_test_busy_reg(indicator_test_busy_reg),
    .out_of_service_reg(out_of_service_reg), .oos_led_reg(oos_led_reg),
    .alarm_reg(alarm_reg), .cot_reg(cot_reg));

/* File: verif/ctc_commission_test_tb_top.sv */
`timescale 1ns/1ps
`include "ctc_consts.vh"
module ctc_commission_test_tb_top;
    logic         clock = 1'b0;
    logic         rst_b = 1'b0;
    logic [15:0]  opto_in = 16'h0;
    logic [15:0]  tmap = 16'h0;
    logic [511:0] bus = '0;
    logic [13:0]  cmd = 14'h0;
    logic [13:0]  pdat = 14'h0;
    logic [13:0]  p;
    logic [7:0]   led = 8'h0;
    logic         sel_wr = 1'b0, mode_wr = 1'b0, pat_wr = 1'b0;
    logic         ct_wr = 1'b0, ind = 1'b0;
    logic [2:0]   sel_idx = 3'h0;
    logic [8:0]   sel_data = 9'h0;
    logic [1:0]   mode_d = 2'h0, ct_d = 2'h0, mode_m = 2'h0;
    logic [31:0]  lfsr = 32'h3084;
    wire  [15:0]  ov;
    wire  [13:0]  cv, drv, pv;
    wire  [7:0]   prb, mon, isv, ldr, cot;
    wire  [1:0]   mv, ctv;
    wire          busy, oos, oled, alm, pvis;
    int           num_errors = 0, samples_checked = 0, cyc = 0;
    int           sel_m [8];
    ctc_commission_test #(.PRESCALE(4), .TEST_TICKS(3)) dut_u (
        .clock(clock), .rst_b(rst_b), .opto_in(opto_in),
        .opto_test_map(tmap), .internal_signal_bus(bus), .contact_cmd(cmd),
        .led_logic(led), .sel_wr(sel_wr), .sel_idx(sel_idx),
        .sel_data(sel_data), .mode_wr(mode_wr), .mode_data(mode_d),
        .pattern_wr(pat_wr), .pattern_data(pdat), .contact_test_wr(ct_wr),
        .contact_test_data(ct_d), .indicator_test_command(ind),
        .opto_view_reg(ov), .contact_view_reg(cv), .probe_view_reg(prb),
        .monitor_port_reg(mon), .indicator_state_view(isv),
        .led_drive_reg(ldr), .contact_drive_reg(drv), .mode_view_reg(mv),
        .pattern_view_reg(pv), .pattern_visible_reg(pvis),
        .contact_test_view_reg(ctv), .indicator_test_busy_reg(busy),
        .out_of_service_reg(oos), .oos_led_reg(oled), .alarm_reg(alm),
        .cot_reg(cot));
    always #12.5 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    function logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function logic [7:0] pexp();
        for (int k = 0; k < 8; k++)
            pexp[k] = bus[sel_m[k]];
    endfunction
    task report_and_stop();
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one strobe for one cycle, then an idle cycle; data fields share the word
    task wr(input int k, input logic [13:0] d);
        {sel_idx, sel_data} = d[11:0];
        mode_d = d[1:0];
        ct_d = d[1:0];
        pdat = d;
        {sel_wr, mode_wr, pat_wr, ct_wr, ind} = 5'h10 >> k;
        if (k == 0)
            sel_m[d[11:9]] = d[8:0];
        if (k == 1 && d[1:0] != 2'h3)
            mode_m = d[1:0];
        @(negedge clock);
        {sel_wr, mode_wr, pat_wr, ct_wr, ind} = 5'h0;
        @(negedge clock);
    endtask
    initial
    begin
        for (int k = 0; k < 8; k++)
            sel_m[k] = 64 + k;
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        chk(mv, `CTC_MODE_DISABLED);
        chk(pv, 14'h0);
        wr(0, 14'({3'h7, 9'h1FF}));
        repeat (10)
        begin
            bus = {16{rnd()}};
            opto_in = 16'(rnd());
            cmd = 14'(rnd());
            led = 8'(rnd());
            wr(0, 14'(rnd()));
            repeat (4) @(negedge clock);
            chk(ov, opto_in);
            chk(cv, cmd);
            chk(isv, led);
            chk(prb, pexp());
            chk(mon, pexp());
        end
        for (int m = 3; m >= 0; m--)
        begin
            cmd = 14'(rnd());
            p = 14'(rnd());
            wr(1, 14'(m));
            @(negedge clock);
            wr(2, p);
            wr(3, 14'(`CTC_CMD_APPLY));
            repeat (3) @(negedge clock);
            chk(mv, mode_m);
            chk({oos, oled, alm}, {3{mode_m != 2'h0}});
            chk(pv, mode_m == 2'h2 ? p : 14'h0);
            chk(drv, mode_m == 2'h2 ? p : cmd);
            chk(ctv, `CTC_CMD_NOP);
            chk(pvis, mode_m == 2'h2);
            wr(3, 14'(`CTC_CMD_REMOVE));
            repeat (3) @(negedge clock);
            chk(cv, cmd);
            chk(drv, mode_m == 2'h2 ? 14'h0 : cmd);
        end
        tmap = 16'h1 << rnd() % 16;
        opto_in = tmap;
        repeat (5) @(negedge clock);
        chk(oos, 1'b1);
        chk(cot, `CTC_COT_TEST);
        opto_in = 16'h0;
        repeat (5) @(negedge clock);
        chk(cot, `CTC_COT_NORMAL);
        wr(4, 14'h0);
        @(negedge clock);
        chk({isv, ldr, busy}, {16'hFFFF, 1'b1});
        repeat (6) @(negedge clock);
        wr(4, 14'h0);
        repeat (10) @(negedge clock);
        chk({isv, busy}, {led, 1'b0});
        report_and_stop();
    end
endmodule // ctc_commission_test_tb_top
